// ==== inc/timer16_pkg.sv ====
// constants and carrier types for the 16-bit timer wave/mode control block
package timer16_pkg;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 16;
  localparam int FILTER_LEN = 4;
  // register indices on the 8-bit cpu port
  localparam logic [3:0] REG_CTRL_A = 4'h0;
  localparam logic [3:0] REG_CTRL_B = 4'h1;
  localparam logic [3:0] REG_CNT_L = 4'h2;
  localparam logic [3:0] REG_CNT_H = 4'h3;
  localparam logic [3:0] REG_CMPA_L = 4'h4;
  localparam logic [3:0] REG_CMPA_H = 4'h5;
  localparam logic [3:0] REG_CMPB_L = 4'h6;
  localparam logic [3:0] REG_CMPB_H = 4'h7;
  localparam logic [3:0] REG_CAP_L = 4'h8;
  localparam logic [3:0] REG_CAP_H = 4'h9;
  // field positions
  localparam int ACT_A_HI = 7;
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_HI = 5;
  localparam int ACT_B_LO = 4;
  localparam int MODE_LO_HI = 1;
  localparam int MODE_LO_LO = 0;
  localparam int MODE_HI_HI = 4;
  localparam int MODE_HI_LO = 3;
  localparam int FILTER_EN_BIT = 7;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  // fixed counter limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] MAX = 16'hFFFF;
  // action field codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    WAVE_NONPWM,
    WAVE_FAST,
    WAVE_DUAL,
    WAVE_NONE
  } wave_kind_e;

  typedef struct packed {
    wave_kind_e kind;
    logic [15:0] top_fixed;
    logic top_cmpa;
    logic top_cap;
    logic upd_now;
    logic upd_top;
    logic upd_bottom;
    logic ovf_max;
    logic ovf_top;
    logic ovf_bottom;
  } mode_info_s;

  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cpu_req_s;
endpackage

// ==== verilog/timer16_wave_mode_control.sv ====
// 16-bit timer with mode table, two compare outputs and capture filter
// What this block does
// - action fields at control A bits 7:6, 5:4
// - nonzero action overrides pin; direction gates drive
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: 10 clear-match/set-bottom, 11 inverse
// - PWM 01: off, or toggle A if top bit
// - dual-slope: 10 clear up, set down; 11 inverse
// - fast PWM 10/11: compare equal TOP ignores match
// - mode from control A 1:0 and B
// - fixed-top modes: buffered at TOP, own overflow
// - normal and clear-on-match: immediate update, MAX flag
// - phase-frequency modes: update and flag at BOTTOM
// - phase correct/fast variable TOP; 13 reserved
// - filter needs four equal samples to change
// - shared high-byte holder; low byte transfers all
`timescale 1ns/1ps
module timer16_wave_mode_control
  import timer16_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire cpu_req_s i_cpu,
  output logic [7:0] o_rdata,
  input wire logic i_capture_input_pin,
  input wire logic [1:0] i_port_out,
  input wire logic [1:0] i_dir_out,
  output logic o_chan_a_wave_out,
  output logic o_chan_a_oe_n,
  output logic o_chan_b_wave_out,
  output logic o_chan_b_oe_n,
  output logic o_overflow_flag,
  output logic o_capture_event
);
  logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, temp_q, temp_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] cnt_q, cnt_d, cap_q, cap_d, top;
  logic [15:0] buf_q [2];
  logic [15:0] buf_d [2];
  logic [15:0] cmp_q [2];
  logic [15:0] cmp_d [2];
  logic down_q, down_d, ovf_q, ovf_d, capev_q, capev_d;
  logic [FILTER_LEN-1:0] samp_q, samp_d;
  logic filt_q, filt_d, prev_q, prev_d, sel, cnt_wr;
  logic [3:0] wave_mode_sel;
  logic [1:0] act [2];
  logic [1:0] wave_q, pin_q, oe_n_q;
  mode_info_s mi;

  assign wave_mode_sel = {ctrl_b_q[MODE_HI_HI:MODE_HI_LO],
                          ctrl_a_q[MODE_LO_HI:MODE_LO_LO]};
  assign act[0] = ctrl_a_q[ACT_A_HI:ACT_A_LO];
  assign act[1] = ctrl_a_q[ACT_B_HI:ACT_B_LO];
  assign cnt_wr = i_cpu.wr && i_cpu.addr == REG_CNT_L;

  // mode table decode
  always_comb begin
    mi = '0;
    mi.kind = WAVE_DUAL;
    mi.top_fixed = MAX;
    case (wave_mode_sel)
      4'h0, 4'h4, 4'hC: begin
        mi.kind = WAVE_NONPWM;
        mi.top_cmpa = wave_mode_sel == 4'h4;
        mi.top_cap = wave_mode_sel == 4'hC;
        mi.upd_now = 1'b1;
        mi.ovf_max = 1'b1;
      end
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin
        mi.top_fixed = wave_mode_sel[1] ?
                       (wave_mode_sel[0] ? TOP_10 : TOP_9) : TOP_8;
        mi.top_cap = wave_mode_sel == 4'hA;
        mi.top_cmpa = wave_mode_sel == 4'hB;
        mi.upd_top = 1'b1;
        mi.ovf_bottom = 1'b1;
      end
      4'h8, 4'h9: begin
        mi.top_cap = !wave_mode_sel[0];
        mi.top_cmpa = wave_mode_sel[0];
        mi.upd_bottom = 1'b1;
        mi.ovf_bottom = 1'b1;
      end
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
        mi.kind = WAVE_FAST;
        mi.top_fixed = wave_mode_sel[1] ?
                       (wave_mode_sel[0] ? TOP_10 : TOP_9) : TOP_8;
        mi.top_cap = wave_mode_sel == 4'hE;
        mi.top_cmpa = wave_mode_sel == 4'hF;
        mi.upd_top = 1'b1;
        mi.ovf_top = 1'b1;
      end
      default: mi.kind = WAVE_NONE;
    endcase
  end

  assign top = mi.top_cmpa ? cmp_q[0] : (mi.top_cap ? cap_q : mi.top_fixed);

  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    temp_d = temp_q;
    rdata_d = 8'h00;
    cnt_d = cnt_q;
    down_d = down_q;
    cap_d = cap_q;
    buf_d = buf_q;
    cmp_d = cmp_q;
    // read side: counter and capture low byte reads park the high byte in the shared holder
    if (i_cpu.rd) begin
      case (i_cpu.addr)
        REG_CTRL_A: rdata_d = ctrl_a_q;
        REG_CTRL_B: rdata_d = ctrl_b_q;
        REG_CNT_L: begin
          rdata_d = cnt_q[7:0];
          temp_d = cnt_q[15:8];
        end
        REG_CAP_L: begin
          rdata_d = cap_q[7:0];
          temp_d = cap_q[15:8];
        end
        REG_CNT_H, REG_CAP_H: rdata_d = temp_q;
        // compare reads bypass the holder
        REG_CMPA_L: rdata_d = buf_q[0][7:0];
        REG_CMPA_H: rdata_d = buf_q[0][15:8];
        REG_CMPB_L: rdata_d = buf_q[1][7:0];
        REG_CMPB_H: rdata_d = buf_q[1][15:8];
        default: rdata_d = 8'h00;
      endcase
    end
    // counting sequence
    if (mi.kind == WAVE_DUAL) begin
      if (!down_q && cnt_q >= top) begin
        down_d = 1'b1;
        cnt_d = cnt_q - 16'h0001;
      end else if (down_q && cnt_q == BOTTOM) begin
        down_d = 1'b0;
        cnt_d = cnt_q + 16'h0001;
      end else begin
        cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
    end else begin
      down_d = 1'b0;
      cnt_d = (cnt_q >= top) ? BOTTOM : cnt_q + 16'h0001;
    end
    // compare buffer transfer point
    for (int i = 0; i < 2; i++) begin
      if (mi.upd_now || (mi.upd_top && cnt_q == top) ||
          (mi.upd_bottom && cnt_q == BOTTOM))
        cmp_d[i] = buf_q[i];
    end
    // capture: disconnected while the capture register sets TOP
    if (sel && !prev_q && !mi.top_cap)
      cap_d = cnt_q;
    // write side: all 16-bit low-byte writes take the holder in one cycle
    if (i_cpu.wr) begin
      case (i_cpu.addr)
        REG_CTRL_A: ctrl_a_d = i_cpu.wdata;
        REG_CTRL_B: ctrl_b_d = i_cpu.wdata;
        REG_CNT_H, REG_CMPA_H, REG_CMPB_H, REG_CAP_H:
          temp_d = i_cpu.wdata;
        REG_CNT_L: cnt_d = {temp_q, i_cpu.wdata};
        REG_CMPA_L: buf_d[0] = {temp_q, i_cpu.wdata};
        REG_CMPB_L: buf_d[1] = {temp_q, i_cpu.wdata};
        REG_CAP_L: cap_d = {temp_q, i_cpu.wdata};
        default: ;
      endcase
    end
    ovf_d = (mi.ovf_max && cnt_q == MAX) || (mi.ovf_top && cnt_q == top) ||
            (mi.ovf_bottom && down_q && cnt_q == BOTTOM);
    capev_d = sel && !prev_q && !mi.top_cap;
  end

  // capture filter: output moves only on a full run of equal samples
  assign samp_d = {samp_q[FILTER_LEN-2:0], i_capture_input_pin};
  always_comb begin
    filt_d = filt_q;
    if (&samp_q)
      filt_d = 1'b1;
    else if (~|samp_q)
      filt_d = 1'b0;
  end
  assign sel = ctrl_b_q[FILTER_EN_BIT] ? filt_q : samp_q[0];
  assign prev_d = sel;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_a_q <= CTRL_A_RST;
      ctrl_b_q <= CTRL_B_RST;
      temp_q <= TEMP_RST;
      rdata_q <= 8'h00;
      cnt_q <= VAL_RST;
      down_q <= 1'b0;
      cap_q <= VAL_RST;
      buf_q <= '{VAL_RST, VAL_RST};
      cmp_q <= '{VAL_RST, VAL_RST};
      ovf_q <= 1'b0;
      capev_q <= 1'b0;
      samp_q <= '0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      temp_q <= temp_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      down_q <= down_d;
      cap_q <= cap_d;
      buf_q <= buf_d;
      cmp_q <= cmp_d;
      ovf_q <= ovf_d;
      capev_q <= capev_d;
      samp_q <= samp_d;
      filt_q <= filt_d;
      prev_q <= prev_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic match, wave_d, pin_d, ovr;
    always_comb begin
      match = cnt_q == cmp_q[g];
      wave_d = wave_q[g];
      ovr = act[g] != ACT_OFF && mi.kind != WAVE_NONE;
      if (mi.kind == WAVE_NONPWM && match) begin
        case (act[g])
          ACT_TOGGLE: wave_d = !wave_q[g];
          ACT_CLEAR: wave_d = 1'b0;
          ACT_SET: wave_d = 1'b1;
          default: ;
        endcase
      end else if (mi.kind == WAVE_FAST || mi.kind == WAVE_DUAL) begin
        if (act[g] == ACT_TOGGLE) begin
          // code 01 only drives channel A, and only with the top mode bit
          ovr = wave_mode_sel[3] && g == 0;
          if (ovr && match)
            wave_d = !wave_q[g];
        end else if (act[g][1] && mi.kind == WAVE_FAST) begin
          if (cnt_q == BOTTOM)
            wave_d = !act[g][0];
          if (match && cmp_q[g] != top)
            wave_d = act[g][0];
        end else if (act[g][1] && match) begin
          wave_d = down_q ? !act[g][0] : act[g][0];
        end
      end
      pin_d = ovr ? wave_d : i_port_out[g];
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        wave_q[g] <= 1'b0;
        pin_q[g] <= 1'b0;
        oe_n_q[g] <= 1'b1;
      end else begin
        wave_q[g] <= wave_d;
        pin_q[g] <= pin_d;
        oe_n_q[g] <= !i_dir_out[g];
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_chan_a_wave_out = pin_q[0];
  assign o_chan_b_wave_out = pin_q[1];
  assign o_chan_a_oe_n = oe_n_q[0];
  assign o_chan_b_oe_n = oe_n_q[1];
  assign o_overflow_flag = ovf_q;
  assign o_capture_event = capev_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_act_map;
    i_cpu.wr && i_cpu.addr == REG_CTRL_A |=>
      act[0] == $past(i_cpu.wdata[7:6]) && act[1] == $past(i_cpu.wdata[5:4]);
  endproperty
  a_act_map: assert property (p_act_map) else $error("action map");
  property p_dir;
    1'b1 |=> o_chan_a_oe_n == !$past(i_dir_out[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction gate");
  property p_nonpwm_set;
    mi.kind == WAVE_NONPWM && act[1] == ACT_SET && cnt_q == cmp_q[1]
      |=> wave_q[1];
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("set");
  property p_fast_bottom;
    mi.kind == WAVE_FAST && act[0] == ACT_CLEAR && cnt_q == BOTTOM &&
      cmp_q[0] != BOTTOM |=> wave_q[0];
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("bottom");
  property p_pwm_off;
    mi.kind == WAVE_FAST && act[0] == ACT_TOGGLE && !wave_mode_sel[3]
      |=> o_chan_a_wave_out == $past(i_port_out[0]);
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("01 off");
  property p_dual_up;
    mi.kind == WAVE_DUAL && act[0] == ACT_CLEAR && !down_q &&
      cnt_q == cmp_q[0] |=> !wave_q[0];
  endproperty
  a_dual_up: assert property (p_dual_up) else $error("dual up");
  property p_top_ignore;
    mi.kind == WAVE_FAST && act[0] == ACT_CLEAR && cmp_q[0] == top &&
      cnt_q == top && cnt_q != BOTTOM |=> $stable(wave_q[0]);
  endproperty
  a_top_ignore: assert property (p_top_ignore) else $error("top");
  // a counter write or a zero TOP just after the wrap moves the second step
  property p_wrap;
    mi.kind != WAVE_DUAL && cnt_q >= top && !cnt_wr
      |=> cnt_q == BOTTOM ##1
        (cnt_q == 16'h0001 || $past(cnt_wr) || $past(top) == BOTTOM);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_low_write;
    cnt_wr |=> cnt_q == {$past(temp_q), $past(i_cpu.wdata)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("16-bit");
  property p_filter;
    filt_q != $past(filt_q) |-> $past(samp_q) == {FILTER_LEN{filt_q}};
  endproperty
  a_filter: assert property (p_filter) else $error("filter");
endmodule

// ==== tb/timer16_wave_mode_control_tb.sv ====
// self-checking bench for the 16-bit timer wave and mode control block
`timescale 1ns/1ps
module timer16_wave_mode_control_tb;
  import timer16_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_capture_input_pin = 1'b0;
  cpu_req_s i_cpu = '0;
  logic [1:0] i_port_out = 2'h0;
  logic [1:0] i_dir_out = 2'h0;
  logic [7:0] o_rdata;
  logic o_chan_a_wave_out, o_chan_a_oe_n, o_chan_b_wave_out, o_chan_b_oe_n;
  logic o_overflow_flag, o_capture_event;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 25218;
  int n, ha, hb, d, f0, f1;
  logic [7:0] rv, lo;
  int exp_b[4] = '{40, 20, 0, 40};
  int modes[12] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 14, 15};

  always #10 i_clk = ~i_clk;

  timer16_wave_mode_control i_timer16_wave_mode_control (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cpu(i_cpu), .o_rdata(o_rdata),
    .i_capture_input_pin(i_capture_input_pin), .i_port_out(i_port_out),
    .i_dir_out(i_dir_out), .o_chan_a_wave_out(o_chan_a_wave_out),
    .o_chan_a_oe_n(o_chan_a_oe_n), .o_chan_b_wave_out(o_chan_b_wave_out),
    .o_chan_b_oe_n(o_chan_b_oe_n), .o_overflow_flag(o_overflow_flag),
    .o_capture_event(o_capture_event));

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge i_clk);
    i_cpu <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge i_clk);
    i_cpu <= '0;
  endtask

  task automatic rd(logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_cpu <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge i_clk);
    i_cpu <= '0;
    #1 v = o_rdata;
  endtask

  // high byte first into the shared holder, low byte completes the transfer
  task automatic wr16(logic [3:0] hi, logic [15:0] v);
    wr(hi, v[15:8]);
    wr(hi - 4'h1, v[7:0]);
  endtask

  // counter is cleared so each mode starts from a known point
  task automatic setm(logic [3:0] m, logic [1:0] aa, ab, logic f);
    wr(REG_CTRL_B, {f, 2'h0, m[3:2], 3'h0});
    wr(REG_CTRL_A, {aa, ab, 2'h0, m[1:0]});
    wr16(REG_CNT_H, 16'h0000);
  endtask

  // compares are loaded in mode 0, where they reach the active copy at once
  task automatic cfg(logic [3:0] m, logic [1:0] aa, ab, logic [15:0] ca, cb);
    setm(4'h0, 2'h0, 2'h0, 1'b0);
    wr16(REG_CMPA_H, ca);
    wr16(REG_CMPB_H, cb);
    wr16(REG_CAP_H, ca);
    setm(m, aa, ab, 1'b0);
  endtask

  task automatic win(int w, output int a, output int b);
    a = 0;
    b = 0;
    repeat (w) begin
      @(posedge i_clk);
      #1;
      a += (o_chan_a_wave_out === 1'b1);
      b += (o_chan_b_wave_out === 1'b1);
    end
  endtask

  // the second gap is measured: the first may straddle the mode change
  task automatic ovf_gap(output int g);
    g = 0;
    for (int k = 0; k < 2; k++) begin
      g = 0;
      do begin
        @(posedge i_clk);
        #1;
        g++;
      end while (o_overflow_flag !== 1'b1 && g < 5000);
    end
    if (g >= 5000) begin
      error_cnt++;
      $display("wrong value overflow_wait expected pulse seen none");
      conclude();
    end
  endtask

  task automatic cap_pulse(int len, output int got, output int first);
    got = 0;
    first = -1;
    for (int k = 0; k < len + 12; k++) begin
      @(posedge i_clk);
      i_capture_input_pin <= (k < len);
      #1;
      if (o_capture_event === 1'b1 && first < 0) first = k;
      got += (o_capture_event === 1'b1);
    end
  endtask

  function automatic int exp_gap(int m, int t);
    case (m)
      1, 2, 3: return 2 * ((256 << (m - 1)) - 1);
      5, 6, 7: return 256 << (m - 5);
      14, 15: return t + 1;
      default: return 2 * t;
    endcase
  endfunction

  initial begin
    repeat (15) @(posedge i_clk);
    #1;
    chk("wave_a_rst", 16'h0, o_chan_a_wave_out);
    chk("oe_a_rst", 16'h1, o_chan_a_oe_n);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(REG_CTRL_A, rv);
    chk("ctrl_a_rst", CTRL_A_RST, rv);
    rd(REG_CTRL_B, rv);
    chk("ctrl_b_rst", CTRL_B_RST, rv);
    repeat (4) begin
      d = $random(seed);
      wr(REG_CTRL_A, d[7:0] & 8'hF3);
      rd(REG_CTRL_A, rv);
      chk("ctrl_a", d[7:0] & 8'hF3, rv);
      wr(REG_CTRL_B, d[15:8] & 8'h98);
      rd(REG_CTRL_B, rv);
      chk("ctrl_b", d[15:8] & 8'h98, rv);
    end
    wr(4'hF, 8'hFF);
    rd(4'hA, rv);
    chk("unmapped", 16'h0, rv);
    $display("register test done");
    setm(4'h0, 2'h0, 2'h0, 1'b0);
    wr(REG_CMPA_H, 8'h3C);
    wr(REG_CMPA_L, 8'h11);
    wr(REG_CMPB_L, 8'h22);
    wr(REG_CAP_H, 8'h77);
    rd(REG_CMPB_L, rv);
    chk("cmpb_lo", 16'h22, rv);
    rd(REG_CMPB_H, rv);
    chk("cmpb_hi", 16'h3C, rv);
    wr16(REG_CNT_H, 16'h1200);
    rd(REG_CNT_L, lo);
    rd(REG_CNT_H, rv);
    chk("cnt_hi", 16'h12, rv);
    chk("cnt_lo_near", 16'h1, lo < 8'h10);
    wr16(REG_CAP_H, 16'h5AC3);
    rd(REG_CAP_L, lo);
    rd(REG_CAP_H, rv);
    chk("cap_lo", 16'hC3, lo);
    chk("cap_hi", 16'h5A, rv);
    wr16(REG_CNT_H, 16'hFFF0);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_overflow_flag !== 1'b1 && n < 40);
    chk("ovf_max_delay", 16'd16, 16'(n));
    $display("sixteen-bit access test done");
    repeat (8) begin
      @(posedge i_clk);
      i_port_out <= 2'($random(seed));
      i_dir_out <= 2'($random(seed));
      @(posedge i_clk);
      #1;
      chk("pin_a", 16'(i_port_out[0]), o_chan_a_wave_out);
      chk("pin_b", 16'(i_port_out[1]), o_chan_b_wave_out);
      chk("oe_a", 16'(!i_dir_out[0]), o_chan_a_oe_n);
      chk("oe_b", 16'(!i_dir_out[1]), o_chan_b_oe_n);
    end
    @(posedge i_clk);
    i_port_out <= 2'h2;
    i_dir_out <= 2'h3;
    for (int c = 0; c < 4; c++) begin
      // odd passes take TOP from capture, which holds the same limit
      cfg(c[0] ? 4'hC : 4'h4, 2'h1, 2'(c), 16'h0009, 16'h0004);
      win(20, ha, hb);
      win(40, ha, hb);
      chk("ctc_a", 16'd20, 16'(ha));
      chk("ctc_b", 16'(exp_b[c]), 16'(hb));
    end
    $display("non-pwm test done");
    d = 1 + (($random(seed) & 32'h7FFFFFFF) % 253);
    cfg(4'h5, 2'h2, 2'h3, 16'(d), 16'(d));
    win(300, ha, hb);
    win(512, ha, hb);
    chk("fast_a", 16'(2 * d), 16'(ha));
    chk("fast_b", 16'(512 - 2 * d), 16'(hb));
    cfg(4'h5, 2'h2, 2'h3, 16'h00FF, 16'h00FF);
    win(300, ha, hb);
    win(512, ha, hb);
    chk("fast_top_a", 16'd512, 16'(ha));
    chk("fast_top_b", 16'd0, 16'(hb));
    cfg(4'h1, 2'h2, 2'h3, 16'(d), 16'(d));
    win(600, ha, hb);
    win(1020, ha, hb);
    chk("dual_a", 16'(4 * d), 16'(ha));
    chk("dual_b", 16'(1020 - 4 * d), 16'(hb));
    $display("pwm test done");
    @(posedge i_clk);
    i_port_out <= 2'h1;
    cfg(4'h5, 2'h1, 2'h1, 16'h0014, 16'h0014);
    win(100, ha, hb);
    chk("pwm01_a_port", 16'd100, 16'(ha));
    chk("pwm01_b_port", 16'd0, 16'(hb));
    cfg(4'hF, 2'h1, 2'h1, 16'h0009, 16'h0004);
    win(20, ha, hb);
    win(40, ha, hb);
    chk("pwm01_a_tgl", 16'd20, 16'(ha));
    chk("pwm01_b_res", 16'd0, 16'(hb));
    cfg(4'hD, 2'h2, 2'h2, 16'h0014, 16'h0014);
    win(50, ha, hb);
    chk("mode13_a", 16'd50, 16'(ha));
    chk("mode13_b", 16'd0, 16'(hb));
    $display("action 01 and reserved mode test done");
    foreach (modes[k]) begin
      cfg(4'(modes[k]), 2'h0, 2'h0, 16'h0014, 16'h0014);
      ovf_gap(n);
      chk("ovf_gap", 16'(exp_gap(modes[k], 20)), 16'(n));
    end
    $display("mode table test done");
    setm(4'h0, 2'h0, 2'h0, 1'b0);
    cap_pulse(1, n, f0);
    chk("cap_raw", 16'd1, 16'(n));
    setm(4'h0, 2'h0, 2'h0, 1'b1);
    cap_pulse(3, n, f1);
    chk("cap_short", 16'd0, 16'(n));
    cap_pulse(8, n, f1);
    chk("cap_long", 16'd1, 16'(n));
    chk("cap_delay", 16'd4, 16'(f1 - f0));
    $display("capture filter test done");
    conclude();
  end
endmodule
